// File: rtl/usb_device_system_control.sv
// usb device system control: system control register, fifo placement table,
// connect/session, suspend/resume, bus reset speed negotiation and interrupt flags
// assumes pin-side inputs are asynchronous levels and an axi4-lite master on aclk
//
// What this block does
// - bit 15 powers the usb module down when 1; resets to 1
// - bit 14 enables the vbus session-end comparator; resets to 0
// - bit 13 enables the vbus detect comparator; resets to 1
// - bit 12 forces the phy pll out of suspend; resets to 0
// - bit 6 selects data-line polarity: 1 normal, 0 swaps d+ and d-
// - bit 3 disables the oscillator bias resistor when 1
// - bit 2 turns the usb oscillator off when 1
// - bits 1-0 pick word, high-byte or low-byte cpu access; 3 reserved
// - 4k fifo ram; per-endpoint start, max size, double buffer, via index
// - only endpoints 1-4 are placeable; endpoint 0 is 64 bytes at 0
// - soft connect plus vbus, with bit 15 clear, starts a session, sets session, adds pull-up
// - interrupts on endpoint done, reset, resume, suspend, connect, disconnect, sof
// - soft connect resets to 0; clearing it disconnects from the host
// - 3 ms without bus activity enters suspend and flags an interrupt
// - resume signalling leaves suspend automatically and flags an interrupt
// - no resume interrupt for a wake-up software started itself
// - bus reset with high speed enabled negotiates; result in status flag
// - the phy pll runs at 60 mhz as the usb-side clock
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module usb_device_system_control import usb_sysctl_pkg::*; #(
  parameter int unsigned SUSPEND_CYCLES = SUSPEND_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic vbus_valid,
  input wire logic bus_activity,
  input wire logic bus_reset,
  input wire logic resume_seen,
  input wire logic hs_handshake_ok,
  input wire logic sof_seen,
  input wire logic [4:0] ep_xfer_done,
  output logic module_power_down,
  output logic session_end_comparator_en,
  output logic vbus_detect_comparator_en,
  output logic pll_suspend_override,
  output logic data_line_polarity,
  output logic osc_bias_resistor_off,
  output logic osc_off,
  output logic [1:0] cpu_access_width_select,
  output logic pullup_en,
  output logic hs_chirp_en,
  output logic resume_drive,
  output logic suspend_active,
  output logic irq
);

  localparam int CNT_W = $clog2(SUSPEND_CYCLES + 1);

  sysctl_type sysctl_reg;
  sysctl_type sysctl_next;
  fifo_cfg_type tx_cfg_reg [1:4];
  fifo_cfg_type rx_cfg_reg [1:4];
  logic [2:0] ep_index_reg;
  logic soft_connect_reg, resume_ctrl_reg, hs_enable_reg;
  logic session_reg, suspend_reg, hs_chirp_reg, hs_active_reg, irq_reg, resume_drive_reg;
  logic [INT_W-1:0] int_status_reg, int_enable_reg, ev_vec;
  logic [CNT_W-1:0] idle_cnt_reg;
  logic [SYN_W-1:0] pins, s1_reg, s2_reg, s3_reg, filt_reg, filt_next, rise_reg;
  logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [15:0] wdata_reg, rd_data, wr_merged;
  logic [1:0] wstrb_reg, bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic do_write, wr_hit, rd_hit, idx_dyn, idle_done;
  logic [13:0] wr_idx;
  power_type power_view;

  // pin inputs pass three flops; a change counts when the last two agree
  assign pins = {ep_xfer_done, sof_seen, hs_handshake_ok, resume_seen, bus_reset,
                 bus_activity, vbus_valid};
  assign filt_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      rise_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      rise_reg <= filt_next & ~filt_reg;
    end
  end

  // axi write channel: address and data taken in any order, response after both
  assign wr_idx = awaddr_reg[ADDR_W-1:2];
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign idx_dyn = (ep_index_reg >= EP_FIRST_DYN) && (ep_index_reg <= EP_LAST_DYN);
  assign wr_hit = (wr_idx >= IDX_SYSCTL) && (wr_idx <= IDX_RX_FIFO);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (awvalid && awready_reg) begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg <= wdata[15:0];
        wstrb_reg <= wstrb[1:0];
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // system control register; a reserved access width code leaves the field as it was
  assign wr_merged = merge16(sysctl_reg, wdata_reg, wstrb_reg);
  always_comb begin
    sysctl_next = sysctl_type'(wr_merged & SYSCTL_WMASK);
    if (sysctl_next.cpu_access_width_select == ACCESS_RESERVED) begin
      sysctl_next.cpu_access_width_select = sysctl_reg.cpu_access_width_select;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysctl_reg <= sysctl_type'(SYSCTL_RESET);
    end else if (do_write && wr_idx == IDX_SYSCTL) begin
      sysctl_reg <= sysctl_next;
    end
  end

  // power controls, endpoint index and interrupt enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_connect_reg <= 1'b0;
      resume_ctrl_reg <= 1'b0;
      hs_enable_reg <= 1'b0;
      ep_index_reg <= '0;
      int_enable_reg <= INT_ENABLE_RESET;
    end else if (do_write) begin
      if (wr_idx == IDX_POWER && wstrb_reg[0]) begin
        soft_connect_reg <= wdata_reg[0];
        resume_ctrl_reg <= wdata_reg[1];
        hs_enable_reg <= wdata_reg[2];
      end
      if (wr_idx == IDX_EP_INDEX && wstrb_reg[0]) begin
        ep_index_reg <= wdata_reg[2:0];
      end
      if (wr_idx == IDX_INT_ENABLE) begin
        int_enable_reg <= INT_W'(merge16({5'h00, int_enable_reg}, wdata_reg, wstrb_reg));
      end
    end
  end

  // indexed fifo placement for endpoints 1-4; endpoint 0 is fixed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 1; i <= 4; i++) begin
        tx_cfg_reg[i] <= '0;
        rx_cfg_reg[i] <= '0;
      end
    end else if (do_write && idx_dyn) begin
      if (wr_idx == IDX_TX_FIFO) begin
        tx_cfg_reg[ep_index_reg] <= fifo_cfg_type'(merge16(tx_cfg_reg[ep_index_reg], wdata_reg,
                                                           wstrb_reg) & FIFO_WMASK);
      end
      if (wr_idx == IDX_RX_FIFO) begin
        rx_cfg_reg[ep_index_reg] <= fifo_cfg_type'(merge16(rx_cfg_reg[ep_index_reg], wdata_reg,
                                                           wstrb_reg) & FIFO_WMASK);
      end
    end
  end

  // read decode
  assign power_view = '{rsvd: '0, session: session_reg, high_speed_active: hs_active_reg,
                        suspended: suspend_reg, high_speed_enable: hs_enable_reg,
                        resume_ctrl: resume_ctrl_reg, soft_connect: soft_connect_reg};
  always_comb begin
    rd_data = 16'h0000;
    rd_hit = 1'b1;
    case (araddr[ADDR_W-1:2])
      IDX_SYSCTL: rd_data = 16'(sysctl_reg) & SYSCTL_WMASK;
      IDX_POWER: rd_data = 16'(power_view);
      IDX_INT_STATUS: rd_data = 16'(int_status_reg);
      IDX_INT_ENABLE: rd_data = 16'(int_enable_reg);
      IDX_EP_INDEX: rd_data = 16'(ep_index_reg);
      IDX_TX_FIFO: rd_data = (ep_index_reg == 3'h0) ? EP0_FIFO_CFG :
                             (idx_dyn ? 16'(tx_cfg_reg[ep_index_reg]) : 16'h0000);
      IDX_RX_FIFO: rd_data = (ep_index_reg == 3'h0) ? EP0_FIFO_CFG :
                             (idx_dyn ? 16'(rx_cfg_reg[ep_index_reg]) : 16'h0000);
      default: rd_hit = 1'b0;
    endcase
  end

  // axi read channel: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rd_data};
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // session follows soft connect and vbus while the module is powered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      session_reg <= 1'b0;
    end else begin
      session_reg <= soft_connect_reg & filt_reg[SYN_VBUS] & ~sysctl_reg.module_power_down;
    end
  end

  // idle counter: restarts on any bus activity, expiry enters suspend
  assign idle_done = (idle_cnt_reg == CNT_W'(SUSPEND_CYCLES - 1)) & ~filt_reg[SYN_ACTIVITY];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt_reg <= '0;
    end else if (!session_reg || suspend_reg || filt_reg[SYN_ACTIVITY] || idle_done) begin
      idle_cnt_reg <= '0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
  end

  // suspend state: entered by idle, left by resume, end of own wake-up, or bus reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suspend_reg <= 1'b0;
      resume_drive_reg <= 1'b0;
    end else begin
      if (!session_reg || rise_reg[SYN_BUS_RESET] || (suspend_reg && rise_reg[SYN_RESUME]) ||
          (resume_drive_reg && !resume_ctrl_reg)) begin
        suspend_reg <= 1'b0;
      end else if (session_reg && !suspend_reg && idle_done) begin
        suspend_reg <= 1'b1;
      end
      resume_drive_reg <= resume_ctrl_reg & suspend_reg;
    end
  end

  // high-speed negotiation while bus reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_chirp_reg <= 1'b0;
      hs_active_reg <= 1'b0;
    end else begin
      hs_chirp_reg <= filt_reg[SYN_BUS_RESET] & hs_enable_reg & session_reg;
      if (!session_reg || rise_reg[SYN_BUS_RESET]) begin
        hs_active_reg <= 1'b0;
      end else if (hs_chirp_reg && rise_reg[SYN_HS_OK]) begin
        hs_active_reg <= 1'b1;
      end
    end
  end

  // event flags: set wins over a write-one-to-clear in the same cycle
  always_comb begin
    ev_vec = '0;
    ev_vec[INT_SUSPEND] = session_reg & ~suspend_reg & idle_done;
    ev_vec[INT_RESUME] = suspend_reg & rise_reg[SYN_RESUME] & ~resume_ctrl_reg;
    ev_vec[INT_RESET] = session_reg & rise_reg[SYN_BUS_RESET];
    ev_vec[INT_SOF] = session_reg & rise_reg[SYN_SOF];
    ev_vec[INT_CONNECT] = soft_connect_reg & filt_reg[SYN_VBUS] &
                          ~sysctl_reg.module_power_down & ~session_reg;
    ev_vec[INT_DISCONNECT] = session_reg & ~(soft_connect_reg & filt_reg[SYN_VBUS] &
                                             ~sysctl_reg.module_power_down);
    ev_vec[INT_W-1:INT_EP0] = rise_reg[SYN_W-1:SYN_EP0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (do_write && wr_idx == IDX_INT_STATUS) begin
        int_status_reg <= (int_status_reg & ~INT_W'(wdata_reg & {{8{wstrb_reg[1]}},
                           {8{wstrb_reg[0]}}})) | ev_vec;
      end else begin
        int_status_reg <= int_status_reg | ev_vec;
      end
      irq_reg <= |(int_status_reg & int_enable_reg);
    end
  end

  // outputs straight from flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign module_power_down = sysctl_reg.module_power_down;
  assign session_end_comparator_en = sysctl_reg.session_end_comparator_en;
  assign vbus_detect_comparator_en = sysctl_reg.vbus_detect_comparator_en;
  assign pll_suspend_override = sysctl_reg.pll_suspend_override;
  assign data_line_polarity = sysctl_reg.data_line_polarity;
  assign osc_bias_resistor_off = sysctl_reg.osc_bias_resistor_off;
  assign osc_off = sysctl_reg.osc_off;
  assign cpu_access_width_select = sysctl_reg.cpu_access_width_select;
  assign pullup_en = session_reg;
  assign hs_chirp_en = hs_chirp_reg;
  assign resume_drive = resume_drive_reg;
  assign suspend_active = suspend_reg;
  assign irq = irq_reg;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sysctl_fields: assert property (
    (do_write && wr_idx == IDX_SYSCTL && wstrb_reg == 2'h3) |=>
      ({module_power_down, session_end_comparator_en, vbus_detect_comparator_en,
        pll_suspend_override, data_line_polarity, osc_bias_resistor_off, osc_off} ==
       {$past(wdata_reg[15:12]), $past(wdata_reg[6]), $past(wdata_reg[3:2])}))
    else $error("system control fields did not take the written value");
  chk_reserved_zero: assert property (
    (arvalid && arready && araddr[ADDR_W-1:2] == IDX_SYSCTL) |=> (rdata[11:7] == 5'h00 &&
      rdata[5:4] == 2'h0)) else $error("reserved control bits read nonzero");
  chk_width_code: assert property (cpu_access_width_select != ACCESS_RESERVED)
    else $error("reserved access width code stored");
  chk_fifo_store: assert property (
    (do_write && wr_idx == IDX_TX_FIFO && idx_dyn && wstrb_reg == 2'h3) |=>
      (16'(tx_cfg_reg[$past(ep_index_reg)]) == ($past(wdata_reg) & FIFO_WMASK)))
    else $error("fifo placement not stored");
  chk_ep0_fixed: assert property (
    (arvalid && arready && ep_index_reg == 3'h0 && (araddr[ADDR_W-1:2] == IDX_TX_FIFO ||
      araddr[ADDR_W-1:2] == IDX_RX_FIFO)) |=> (rdata == {16'h0000, EP0_FIFO_CFG}))
    else $error("endpoint 0 placement not fixed");
  chk_vbus_session: assert property (
    (soft_connect_reg && filt_reg[SYN_VBUS] && !module_power_down) |=> pullup_en)
    else $error("session did not start on vbus");
  chk_soft_disconnect: assert property (!soft_connect_reg |=> !pullup_en)
    else $error("pull-up on without soft connect");
  chk_event_sticky: assert property (
    (ev_vec != '0) |=> ((int_status_reg & $past(ev_vec)) == $past(ev_vec)) ##1 irq ||
      ((int_enable_reg & $past(ev_vec, 2)) == '0)) else $error("event flag lost");
  chk_suspend_entry: assert property (
    (session_reg && !suspend_reg && idle_done) |=> (suspend_active && int_status_reg[INT_SUSPEND]))
    else $error("idle expiry did not suspend");
  chk_resume_exit: assert property ((suspend_reg && rise_reg[SYN_RESUME]) |=> !suspend_active)
    else $error("resume did not end suspend");
  chk_own_wake_quiet: assert property (
    (resume_ctrl_reg && !int_status_reg[INT_RESUME] && !(do_write && wr_idx == IDX_POWER))
      |=> !int_status_reg[INT_RESUME]) else $error("resume flagged for own wake-up");
  chk_hs_negotiate: assert property (
    (filt_reg[SYN_BUS_RESET] && hs_enable_reg && session_reg) |=> hs_chirp_en)
    else $error("high-speed chirp not started");
  chk_hs_result: assert property (
    (session_reg && hs_chirp_reg && rise_reg[SYN_HS_OK] && !rise_reg[SYN_BUS_RESET]) |=>
      hs_active_reg) else $error("high-speed result not reported");
  chk_hs_clear: assert property (rise_reg[SYN_BUS_RESET] |=> !hs_active_reg)
    else $error("high-speed flag kept over bus reset");

  cov_suspend: cover property (session_reg ##1 suspend_reg [*2] ##1 !suspend_reg);
  cov_hs_active: cover property ($rose(hs_active_reg));
  cov_write_done: cover property (bvalid && bready && bresp == RESP_OKAY);

endmodule : usb_device_system_control

`default_nettype wire

// File: common/usb_sysctl_pkg.sv
// constants, register layouts and timing counts for the usb device system control block
// assumes a 25 MHz register clock and a 32-bit axi4-lite register bus
package usb_sysctl_pkg;

  // register indices; byte address is four times the index
  localparam int ADDR_W = 16;
  localparam logic [13:0] IDX_SYSCTL = 14'h1C32;
  localparam logic [13:0] IDX_POWER = 14'h1C33;
  localparam logic [13:0] IDX_INT_STATUS = 14'h1C34;
  localparam logic [13:0] IDX_INT_ENABLE = 14'h1C35;
  localparam logic [13:0] IDX_EP_INDEX = 14'h1C36;
  localparam logic [13:0] IDX_TX_FIFO = 14'h1C37;
  localparam logic [13:0] IDX_RX_FIFO = 14'h1C38;

  // system control register layout
  typedef struct packed {
    logic module_power_down;
    logic session_end_comparator_en;
    logic vbus_detect_comparator_en;
    logic pll_suspend_override;
    logic [4:0] rsvd_hi;
    logic data_line_polarity;
    logic [1:0] rsvd_lo;
    logic osc_bias_resistor_off;
    logic osc_off;
    logic [1:0] cpu_access_width_select;
  } sysctl_type;
  localparam logic [15:0] SYSCTL_RESET = 16'hA040;
  localparam logic [15:0] SYSCTL_WMASK = 16'hF04F;
  localparam logic [1:0] ACCESS_RESERVED = 2'h3;

  // power register layout: low three bits writable, next three read-only
  typedef struct packed {
    logic [9:0] rsvd;
    logic session;
    logic high_speed_active;
    logic suspended;
    logic high_speed_enable;
    logic resume_ctrl;
    logic soft_connect;
  } power_type;

  // per-endpoint fifo placement: start in 8-byte units, size = 8 << code
  typedef struct packed {
    logic [1:0] rsvd;
    logic double_buf;
    logic [3:0] size_code;
    logic [8:0] start;
  } fifo_cfg_type;
  localparam logic [15:0] FIFO_WMASK = 16'h3FFF;
  localparam logic [15:0] EP0_FIFO_CFG = 16'h0600;
  localparam int FIFO_RAM_BYTES = 4096;
  localparam logic [2:0] EP_FIRST_DYN = 3'h1;
  localparam logic [2:0] EP_LAST_DYN = 3'h4;

  // interrupt status bits
  localparam int INT_SUSPEND = 0;
  localparam int INT_RESUME = 1;
  localparam int INT_RESET = 2;
  localparam int INT_SOF = 3;
  localparam int INT_CONNECT = 4;
  localparam int INT_DISCONNECT = 5;
  localparam int INT_EP0 = 6;
  localparam int INT_W = 11;
  localparam logic [INT_W-1:0] INT_ENABLE_RESET = 11'h7FF;

  // synchronised pin inputs
  localparam int SYN_VBUS = 0;
  localparam int SYN_ACTIVITY = 1;
  localparam int SYN_BUS_RESET = 2;
  localparam int SYN_RESUME = 3;
  localparam int SYN_HS_OK = 4;
  localparam int SYN_SOF = 5;
  localparam int SYN_EP0 = 6;
  localparam int SYN_W = 11;

  // timing
  localparam int CLK_KHZ = 25000;
  localparam int SUSPEND_IDLE_US = 3000;
  localparam int SUSPEND_CYCLES_DEF = (SUSPEND_IDLE_US * CLK_KHZ + 999) / 1000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

endpackage : usb_sysctl_pkg

// File: verification/usb_host_model.sv
// host-side model: vbus, bus activity, bus reset, chirp answer and event edges
// assumes the bench calls its tasks; all changes land just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  input wire logic aclk,
  input wire logic hs_chirp_en,
  output logic vbus_valid,
  output logic bus_activity,
  output logic bus_reset,
  output logic hs_handshake_ok,
  output logic [6:0] ev
);
  // bus activity high and no power until told otherwise
  initial begin
    vbus_valid = 1'b0;
    bus_activity = 1'b1;
    bus_reset = 1'b0;
    hs_handshake_ok = 1'b0;
    ev = 7'h00;
  end
  // power and activity levels
  task set(input logic vb, input logic ac);
    @(posedge aclk);
    vbus_valid <= vb;
    bus_activity <= ac;
  endtask : set
  // event edge held long enough for the synchronisers: 0 resume, 1 sof, 2+n endpoint n
  task pulse(input int b);
    @(posedge aclk);
    ev[b] <= 1'b1;
    repeat (6) @(posedge aclk);
    ev[b] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask : pulse
  // bus reset; the chirp is answered only when the device chirps
  task bus_rst;
    int k;
    @(posedge aclk);
    bus_reset <= 1'b1;
    for (k = 0; k < 30 && !hs_chirp_en; k++) @(posedge aclk);
    repeat (4) @(posedge aclk);
    hs_handshake_ok <= hs_chirp_en;
    repeat (6) @(posedge aclk);
    bus_reset <= 1'b0;
    hs_handshake_ok <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : bus_rst
endmodule : usb_host_model
`default_nettype wire

// File: verification/usb_device_system_control_bench.sv
// bench: axi4-lite register tasks plus host model driving the pin side
// assumes SUSPEND_CYCLES is shortened to 50
`timescale 1ns/100ps
`default_nettype none
module usb_device_system_control_bench import usb_sysctl_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, vbus_valid, bus_activity, bus_reset, hs_ok;
  logic [1:0] bresp, rresp, cpu_access_width_select;
  logic [31:0] rdata;
  logic [6:0] ev;
  logic pwd, sess_en, vdet_en, pll_ovr, pol, bias_off, osc_off, pullup_en, hs_chirp_en;
  logic resume_drive, suspend_active, irq;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 aclk = ~aclk;
  usb_device_system_control #(.SUSPEND_CYCLES(50)) u_usb_device_system_control (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .vbus_valid(vbus_valid),
    .bus_activity(bus_activity), .bus_reset(bus_reset), .resume_seen(ev[0]),
    .hs_handshake_ok(hs_ok), .sof_seen(ev[1]), .ep_xfer_done(ev[6:2]),
    .module_power_down(pwd), .session_end_comparator_en(sess_en),
    .vbus_detect_comparator_en(vdet_en), .pll_suspend_override(pll_ovr),
    .data_line_polarity(pol), .osc_bias_resistor_off(bias_off), .osc_off(osc_off),
    .cpu_access_width_select(cpu_access_width_select), .pullup_en(pullup_en),
    .hs_chirp_en(hs_chirp_en), .resume_drive(resume_drive),
    .suspend_active(suspend_active), .irq(irq));
  usb_host_model u_usb_host_model (.aclk(aclk), .hs_chirp_en(hs_chirp_en),
    .vbus_valid(vbus_valid), .bus_activity(bus_activity), .bus_reset(bus_reset),
    .hs_handshake_ok(hs_ok), .ev(ev));
  // verdict and end of run
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // axi4-lite write: address and data offered together, bready held until bvalid
  task wr(input logic [13:0] i, input logic [15:0] v);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {16'h0000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        b = 1'b1;
        bready <= 1'b0;
        chk(bresp, (i >= IDX_SYSCTL && i <= IDX_RX_FIFO) ? RESP_OKAY : RESP_SLVERR);
      end
    end
  endtask : wr
  // axi4-lite read, compared with expected data and response
  task rc(input logic [13:0] i, input logic [15:0] e, input logic [1:0] er);
    logic t;
    t = 1'b0;
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        t = 1'b1;
        rready <= 1'b0;
        chk(rdata, {16'h0000, e});
        chk(rresp, er);
      end
    end
  endtask : rc
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk({pwd, sess_en, vdet_en, pll_ovr, pol}, 5'h15);
    rc(IDX_SYSCTL, 16'hA040, RESP_OKAY);
    wr(IDX_SYSCTL, 16'hF07F);
    rc(IDX_SYSCTL, 16'hF04C, RESP_OKAY);
    chk({pwd, sess_en, pll_ovr, bias_off, osc_off}, 5'h1F);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_SYSCTL, 16'h2000 | 16'(k));
      chk(cpu_access_width_select, (k == 3) ? 2 : k);
    end
    rc(IDX_SYSCTL, 16'h2002, RESP_OKAY);
    chk({pwd, pol, bias_off, osc_off}, 4'h0);
    wr(IDX_SYSCTL, 16'h2040);
    wr(14'h0000, 16'hFFFF);
    rc(14'h0000, 16'h0000, RESP_SLVERR);
    wr(IDX_EP_INDEX, 16'h0000);
    wr(IDX_TX_FIFO, 16'h1234);
    rc(IDX_TX_FIFO, EP0_FIFO_CFG, RESP_OKAY);
    wr(IDX_EP_INDEX, 16'h0004);
    wr(IDX_TX_FIFO, 16'h2A10);
    wr(IDX_RX_FIFO, 16'hCCA0);
    wr(IDX_EP_INDEX, 16'h0005);
    wr(IDX_TX_FIFO, 16'h0111);
    wr(IDX_EP_INDEX, 16'h0004);
    rc(IDX_TX_FIFO, 16'h2A10, RESP_OKAY);
    rc(IDX_RX_FIFO, 16'h0CA0, RESP_OKAY);
    u_usb_host_model.set(1'b1, 1'b1);
    repeat (10) @(posedge aclk);
    chk(pullup_en, 1'b0);
    wr(IDX_POWER, 16'h0005);
    repeat (10) @(posedge aclk);
    chk({pullup_en, irq}, 2'h3);
    rc(IDX_POWER, 16'h0025, RESP_OKAY);
    rc(IDX_INT_STATUS, 16'h0010, RESP_OKAY);
    wr(IDX_INT_STATUS, 16'h07FF);
    u_usb_host_model.bus_rst;
    rc(IDX_POWER, 16'h0035, RESP_OKAY);
    rc(IDX_INT_STATUS, 16'h0004, RESP_OKAY);
    wr(IDX_INT_STATUS, 16'h07FF);
    u_usb_host_model.set(1'b1, 1'b0);
    repeat (70) @(posedge aclk);
    chk(suspend_active, 1'b1);
    u_usb_host_model.pulse(0);
    u_usb_host_model.set(1'b1, 1'b1);
    chk(suspend_active, 1'b0);
    rc(IDX_INT_STATUS, 16'h0003, RESP_OKAY);
    wr(IDX_INT_STATUS, 16'h07FF);
    u_usb_host_model.set(1'b1, 1'b0);
    repeat (70) @(posedge aclk);
    wr(IDX_POWER, 16'h0007);
    repeat (160) @(posedge aclk);
    chk(resume_drive, 1'b1);
    wr(IDX_POWER, 16'h0005);
    u_usb_host_model.set(1'b1, 1'b1);
    repeat (4) @(posedge aclk);
    chk({suspend_active, resume_drive}, 2'h0);
    rc(IDX_INT_STATUS, 16'h0001, RESP_OKAY);
    wr(IDX_INT_STATUS, 16'h07FF);
    wr(IDX_INT_ENABLE, 16'h0000);
    for (int k = 1; k < 7; k++) u_usb_host_model.pulse(k);
    chk(irq, 1'b0);
    rc(IDX_INT_STATUS, 16'h07C8, RESP_OKAY);
    wr(IDX_INT_ENABLE, 16'h07FF);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    wr(IDX_INT_STATUS, 16'h07FF);
    wr(IDX_POWER, 16'h0000);
    repeat (10) @(posedge aclk);
    chk(pullup_en, 1'b0);
    rc(IDX_INT_STATUS, 16'h0020, RESP_OKAY);
    end_sim;
  end
endmodule : usb_device_system_control_bench
`default_nettype wire
